//--- core/phy_mode_consts.svh
// Offsets, fields, reset values and timing counts of the mode register bank
`ifndef PHY_MODE_CONSTS_SVH
`define PHY_MODE_CONSTS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define AXI_ADDR_W      8
`define GMODE_OFS       8'h00
`define CMD_OFS         8'h04
`define PSEL_OFS        8'h08
`define XCTL_OFS        8'h0c
`define BCTL_OFS        8'h10
`define MMODE_OFS       8'h14
`define E3_OFS          8'h18
`define E1_OFS          8'h1c
`define PSTAT_OFS       8'h20
// ==========================================================
// Field positions and codes
`define GMODE_MSB       15
`define GMODE_LSB       14
`define GMODE_SGMII     2'h0
`define GMODE_QSGMII    2'h1
`define SRST_BIT        15
`define ANEG_BIT        12
`define MACX_BIT        12
`define PREF_BIT        11
`define AMS_BIT         10
`define MEDIA_MSB       10
`define MEDIA_LSB       8
`define MEDIA_CUSFP     3'h1
`define MEDIA_1000X     3'h2
`define MEDIA_100FX     3'h3
`define MAC_ANEG_BIT    7
`define AMS_SEL_LSB     6
`define BCAST_BIT       0
`define CMD_EXEC_BIT    15
`define CMD_MASK_MSB    11
`define CMD_MASK_LSB    8
`define OP_MAC_SGMII    8'hf0
`define OP_MAC_QSGMII   8'he0
`define OP_MEDIA_1000X  8'hc1
`define OP_MEDIA_100FX  8'hd1
`define AMS_NONE        2'h0
`define AMS_COPPER      2'h1
`define AMS_SERDES      2'h2
`define CFG_NONE        2'h0
`define CFG_1000X       2'h1
`define CFG_100FX       2'h2
`define CFG_QSGMII      2'h2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// ==========================================================
// Reset values
`define GMODE_RST       2'h0
`define BCTL_RST        16'h1000
`define MMODE_RST       16'h0000
`define E3_RST          16'h0000
`define CMD_RST         16'h0000
// ==========================================================
// Timing
`define CLK_PERIOD_PS   5000
`define SRST_TIME_NS    100
`define CMD_TIME_NS     50
`define SRST_CYCLES ((`SRST_TIME_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define CMD_CYCLES  ((`CMD_TIME_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`endif

//--- core/phy_mode_pkg.sv
// Types shared by the mode register bank
package phy_mode_pkg;
  typedef logic [15:0] half_word_t;
  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_ACK  = 2'b01,
    W_RESP = 2'b11
  } wr_state_t;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_ACK  = 2'b01,
    R_DATA = 2'b11
  } rd_state_t;
  typedef enum logic {
    C_IDLE = 1'b0,
    C_RUN  = 1'b1
  } cmd_state_t;
endpackage

//--- core/port_mode_regs.sv
// Per-port control, pending and active mode registers
`timescale 1ns/1ps
`include "phy_mode_consts.svh"
module port_mode_regs #(
  parameter int RST_CYCLES = `SRST_CYCLES
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  input  wire logic                    bctl_we,
  input  wire logic                    mmode_we,
  input  wire logic                    e3_we,
  input  wire phy_mode_pkg::half_word_t wval,
  input  wire logic                    media_stb,
  input  wire logic [1:0]              media_cfg,
  output logic [15:0]                  bctl_r,
  output logic [15:0]                  mmode_act_r,
  output logic [15:0]                  e3_r,
  output logic [1:0]                   mcfg_r
);
  import phy_mode_pkg::*;
  logic [15:0] pend_r;
  logic [7:0]  cnt_r;
  // ==========================================================
  // Soft reset commits the pending mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bctl_r      <= `BCTL_RST;
      mmode_act_r <= `MMODE_RST;
      pend_r      <= `MMODE_RST;
      e3_r        <= `E3_RST;
      mcfg_r      <= `CFG_NONE;
      cnt_r       <= 8'h00;
    end else if (ce) begin
      if (mmode_we) pend_r <= wval;
      if (e3_we) e3_r <= wval;
      if (media_stb) mcfg_r <= media_cfg;
      if (bctl_we) begin
        bctl_r <= wval;
        cnt_r  <= 8'(RST_CYCLES - 1);
      end else if (bctl_r[`SRST_BIT]) begin
        if (cnt_r == 8'h00) begin
          bctl_r[`SRST_BIT] <= 1'b0;
          mmode_act_r       <= pend_r;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
  // ==========================================================
  // Checks
  hold_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !bctl_r[`SRST_BIT] && !bctl_we |=> $stable(mmode_act_r))
    else $error("active mode changed without soft reset");
  commit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(bctl_r[`SRST_BIT]) && !$past(bctl_we)
    |-> mmode_act_r == $past(pend_r))
    else $error("soft reset end did not commit pending mode");
  srst_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bctl_r[`SRST_BIT] && cnt_r != 8'h00 && !bctl_we |=> bctl_r[`SRST_BIT])
    else $error("soft reset ended too early");
  srst_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && bctl_we && wval[`SRST_BIT]
    |=> bctl_r[`SRST_BIT] && cnt_r == 8'(RST_CYCLES - 1))
    else $error("soft reset count not loaded");
endmodule // port_mode_regs

//--- core/serdes_cmd_exec.sv
// Global SerDes command register and its timed executor
`timescale 1ns/1ps
`include "phy_mode_consts.svh"
module serdes_cmd_exec #(
  parameter int CMD_CYCLES = `CMD_CYCLES
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  input  wire logic                    cmd_we,
  input  wire phy_mode_pkg::half_word_t wval,
  output logic [15:0]                  cmd_r,
  output logic [1:0]                   mac_prep_r,
  output logic                         media_stb_r,
  output logic [3:0]                   media_mask_r,
  output logic [1:0]                   media_cfg_r
);
  import phy_mode_pkg::*;
  cmd_state_t st_r;
  logic [7:0] cnt_r;
  wire  [7:0] op        = cmd_r[7:0];
  wire        is_mac_s  = op == `OP_MAC_SGMII;
  wire        is_mac_q  = op == `OP_MAC_QSGMII;
  wire        is_med_x  = op == `OP_MEDIA_1000X;
  wire        is_med_f  = op == `OP_MEDIA_100FX;
  wire        done      = st_r == C_RUN && cnt_r == 8'h00;
  // ==========================================================
  // Executor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= C_IDLE;
      cnt_r        <= 8'h00;
      cmd_r        <= `CMD_RST;
      mac_prep_r   <= `CFG_NONE;
      media_stb_r  <= 1'b0;
      media_mask_r <= 4'h0;
      media_cfg_r  <= `CFG_NONE;
    end else if (ce) begin
      media_stb_r <= 1'b0;
      if (st_r == C_IDLE && cmd_we) begin
        cmd_r <= wval;
        cnt_r <= 8'(CMD_CYCLES - 1);
        if (wval[`CMD_EXEC_BIT]) st_r <= C_RUN;
      end else if (done) begin
        st_r                <= C_IDLE;
        cmd_r[`CMD_EXEC_BIT] <= 1'b0;
        if (is_mac_s) mac_prep_r <= `CFG_1000X;
        if (is_mac_q) mac_prep_r <= `CFG_QSGMII;
        if (is_med_x || is_med_f) begin
          media_stb_r  <= 1'b1;
          media_mask_r <= cmd_r[`CMD_MASK_MSB:`CMD_MASK_LSB];
          media_cfg_r  <= is_med_x ? `CFG_1000X : `CFG_100FX;
        end
      end else if (st_r == C_RUN) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
  // ==========================================================
  // Checks
  mask_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
    media_stb_r |-> media_mask_r == cmd_r[`CMD_MASK_MSB:`CMD_MASK_LSB]
      && !cmd_r[`CMD_EXEC_BIT])
    else $error("media command mask differs from command");
  stb_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    media_stb_r && ce |=> !media_stb_r)
    else $error("media strobe longer than one cycle");
endmodule // serdes_cmd_exec

//--- core/phy_operating_mode_config.sv
// Operating-mode register bank of a four-port PHY behind AXI4-Lite
`timescale 1ns/1ps
`include "phy_mode_consts.svh"

module phy_operating_mode_config #(
  parameter int SRST_CYCLES = `SRST_CYCLES,
  parameter int CMD_CYCLES  = `CMD_CYCLES
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   ce,
  input  wire logic [`AXI_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`AXI_ADDR_W-1:0] araddr,
  input  wire logic [2:0]             arprot,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [3:0]             copper_link_in,
  input  wire logic [3:0]             serdes_link_in,
  output logic                        mac_if_qsgmii,
  output logic [1:0]                  mac_serdes_prep,
  output logic                        qsgmii_lane0_only,
  output logic [3:0]                  port_framing_1000x,
  output logic [3:0]                  port_speed_1000_only,
  output logic [11:0]                 port_media_mode,
  output logic [3:0]                  port_ams_en,
  output logic [7:0]                  port_media_sel,
  output logic [3:0]                  port_aneg_en,
  output logic [3:0]                  port_mac_aneg_en,
  output logic [7:0]                  port_media_cfg
);
  import phy_mode_pkg::*;
  localparam int PORTS = 4;

  // ==========================================================
  // Helpers
  function automatic logic addr_ok(input logic [`AXI_ADDR_W-1:0] a);
    addr_ok = a == `GMODE_OFS || a == `CMD_OFS || a == `PSEL_OFS ||
              a == `XCTL_OFS || a == `BCTL_OFS || a == `MMODE_OFS ||
              a == `E3_OFS || a == `E1_OFS || a == `PSTAT_OFS;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8],
               strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // State
  wr_state_t              wst_r;
  rd_state_t              rst_r;
  logic [`AXI_ADDR_W-1:0] waddr_r;
  logic [`AXI_ADDR_W-1:0] raddr_r;
  logic [15:0]            wdata_r;
  logic [1:0]             wstrb_r;
  logic [1:0]             gmode_r;
  logic [1:0]             psel_r;
  logic                   bcast_r;
  logic [3:0]             cu_s1_r;
  logic [3:0]             cu_s2_r;
  logic [3:0]             sd_s1_r;
  logic [3:0]             sd_s2_r;
  logic [1:0]             ams_sel_r [PORTS];
  logic [15:0]            bctl_q    [PORTS];
  logic [15:0]            mmode_q   [PORTS];
  logic [15:0]            e3_q      [PORTS];
  logic [1:0]             mcfg_q    [PORTS];
  logic [15:0]            pstat_w   [PORTS];
  logic [1:0]             ams_nxt   [PORTS];
  logic [15:0]            cmd_q;
  logic [1:0]             mac_prep;
  logic                   media_stb;
  logic [3:0]             media_mask;
  logic [1:0]             media_cfg;

  // ==========================================================
  // Access decode
  wire wr_start = ce && wst_r == W_IDLE && rst_r == R_IDLE &&
                  awvalid && wvalid;
  wire rd_start = ce && rst_r == R_IDLE && wst_r == W_IDLE &&
                  arvalid && !(awvalid && wvalid);
  wire wr_go    = ce && wst_r == W_ACK;
  wire [`AXI_ADDR_W-1:0] acc_addr = (wst_r != W_IDLE) ? waddr_r : raddr_r;
  wire acc_ok   = addr_ok(acc_addr);
  wire [15:0] rd_val =
    (acc_addr == `GMODE_OFS) ? {gmode_r, 14'h0000} :
    (acc_addr == `CMD_OFS)   ? cmd_q :
    (acc_addr == `PSEL_OFS)  ? {14'h0000, psel_r} :
    (acc_addr == `XCTL_OFS)  ? {15'h0000, bcast_r} :
    (acc_addr == `BCTL_OFS)  ? bctl_q[psel_r] :
    (acc_addr == `MMODE_OFS) ? mmode_q[psel_r] :
    (acc_addr == `E3_OFS)    ? e3_q[psel_r] :
    (acc_addr == `E1_OFS)    ? {8'h00, ams_sel_r[psel_r], 6'h00} :
    (acc_addr == `PSTAT_OFS) ? pstat_w[psel_r] : 16'h0000;
  wire [15:0] wval     = merge16(rd_val, wdata_r, wstrb_r);
  wire [1:0]  wr_gmode = wval[`GMODE_MSB:`GMODE_LSB];
  wire gmode_legal     = wr_gmode == `GMODE_SGMII ||
                         wr_gmode == `GMODE_QSGMII;
  wire we_gmode = wr_go && waddr_r == `GMODE_OFS && gmode_legal;
  wire we_cmd   = wr_go && waddr_r == `CMD_OFS;
  wire we_psel  = wr_go && waddr_r == `PSEL_OFS;
  wire we_xctl  = wr_go && waddr_r == `XCTL_OFS;
  wire is_qsgmii = gmode_r == `GMODE_QSGMII;

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r   <= W_IDLE;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= 16'h0000;
      wstrb_r <= 2'h0;
    end else if (ce) begin
      case (wst_r)
        W_IDLE: begin
          if (wr_start) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            waddr_r <= awaddr;
            wdata_r <= wdata[15:0];
            wstrb_r <= wstrb[1:0];
            wst_r   <= W_ACK;
          end
        end
        W_ACK: begin
          awready <= 1'b0;
          wready  <= 1'b0;
          bvalid  <= 1'b1;
          bresp   <= acc_ok ? `RESP_OKAY : `RESP_SLVERR;
          wst_r   <= W_RESP;
        end
        W_RESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            wst_r  <= W_IDLE;
          end
        end
        default: wst_r <= W_IDLE;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r   <= R_IDLE;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
      raddr_r <= '0;
    end else if (ce) begin
      case (rst_r)
        R_IDLE: begin
          if (rd_start) begin
            arready <= 1'b1;
            raddr_r <= araddr;
            rst_r   <= R_ACK;
          end
        end
        R_ACK: begin
          arready <= 1'b0;
          rvalid  <= 1'b1;
          rdata   <= {16'h0000, rd_val};
          rresp   <= acc_ok ? `RESP_OKAY : `RESP_SLVERR;
          rst_r   <= R_DATA;
        end
        R_DATA: begin
          if (rready) begin
            rvalid <= 1'b0;
            rst_r  <= R_IDLE;
          end
        end
        default: rst_r <= R_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Global registers and link synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gmode_r <= `GMODE_RST;
      psel_r  <= 2'h0;
      bcast_r <= 1'b0;
      cu_s1_r <= 4'h0;
      cu_s2_r <= 4'h0;
      sd_s1_r <= 4'h0;
      sd_s2_r <= 4'h0;
    end else if (ce) begin
      if (we_gmode) gmode_r <= wr_gmode;
      if (we_psel) psel_r <= wval[1:0];
      if (we_xctl) bcast_r <= wval[`BCAST_BIT];
      cu_s1_r <= copper_link_in;
      cu_s2_r <= cu_s1_r;
      sd_s1_r <= serdes_link_in;
      sd_s2_r <= sd_s1_r;
    end
  end

  // ==========================================================
  // Global SerDes command executor
  serdes_cmd_exec #(
    .CMD_CYCLES (CMD_CYCLES)
  ) u_cmd (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ce           (ce),
    .cmd_we       (we_cmd),
    .wval         (wval),
    .cmd_r        (cmd_q),
    .mac_prep_r   (mac_prep),
    .media_stb_r  (media_stb),
    .media_mask_r (media_mask),
    .media_cfg_r  (media_cfg)
  );

  // ==========================================================
  // Per-port banks and outputs
  genvar i;
  generate
    for (i = 0; i < PORTS; i++) begin : g_port
      wire hit = bcast_r || psel_r == 2'(i);
      wire cu  = cu_s2_r[i];
      wire sd  = sd_s2_r[i];
      port_mode_regs #(
        .RST_CYCLES (SRST_CYCLES)
      ) u_port (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ce          (ce),
        .bctl_we     (wr_go && hit && waddr_r == `BCTL_OFS),
        .mmode_we    (wr_go && hit && waddr_r == `MMODE_OFS),
        .e3_we       (wr_go && hit && waddr_r == `E3_OFS),
        .wval        (wval),
        .media_stb   (media_stb && media_mask[i]),
        .media_cfg   (media_cfg),
        .bctl_r      (bctl_q[i]),
        .mmode_act_r (mmode_q[i]),
        .e3_r        (e3_q[i]),
        .mcfg_r      (mcfg_q[i])
      );
      assign pstat_w[i] = {12'h000, mcfg_q[i], is_qsgmii,
                           mmode_q[i][`MACX_BIT] && !is_qsgmii};
      assign ams_nxt[i] =
        !mmode_q[i][`AMS_BIT] ? `AMS_NONE :
        (cu && sd) ? (mmode_q[i][`PREF_BIT] ? `AMS_SERDES : `AMS_COPPER) :
        cu ? `AMS_COPPER : sd ? `AMS_SERDES : `AMS_NONE;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ams_sel_r[i]               <= `AMS_NONE;
          port_framing_1000x[i]      <= 1'b0;
          port_speed_1000_only[i]    <= 1'b0;
          port_media_mode[3*i +: 3]  <= 3'h0;
          port_ams_en[i]             <= 1'b0;
          port_media_sel[2*i +: 2]   <= `AMS_NONE;
          port_aneg_en[i]            <= 1'b0;
          port_mac_aneg_en[i]        <= 1'b0;
          port_media_cfg[2*i +: 2]   <= `CFG_NONE;
        end else if (ce) begin
          ams_sel_r[i]              <= ams_nxt[i];
          port_framing_1000x[i]     <= mmode_q[i][`MACX_BIT];
          port_speed_1000_only[i]   <= mmode_q[i][`MACX_BIT] &&
                                       !is_qsgmii;
          port_media_mode[3*i +: 3] <=
            mmode_q[i][`MEDIA_MSB:`MEDIA_LSB];
          port_ams_en[i]            <= mmode_q[i][`AMS_BIT];
          port_media_sel[2*i +: 2]  <= ams_sel_r[i];
          port_aneg_en[i]           <= bctl_q[i][`ANEG_BIT];
          port_mac_aneg_en[i]       <= e3_q[i][`MAC_ANEG_BIT];
          port_media_cfg[2*i +: 2]  <= mcfg_q[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_if_qsgmii     <= 1'b0;
      mac_serdes_prep   <= `CFG_NONE;
      qsgmii_lane0_only <= 1'b0;
    end else if (ce) begin
      mac_if_qsgmii     <= is_qsgmii;
      mac_serdes_prep   <= mac_prep;
      qsgmii_lane0_only <= is_qsgmii && (|port_media_mode);
    end
  end

  // ==========================================================
  // Checks
  gmode_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && waddr_r == `GMODE_OFS && !gmode_legal |=> $stable(gmode_r))
    else $error("reserved global mode code was stored");
  speed_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    port_framing_1000x[0] && !mac_if_qsgmii |-> port_speed_1000_only[0])
    else $error("1000BASE-X MAC port not locked to 1000 Mbps");
  qsgmii_speed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mac_if_qsgmii && $stable(mac_if_qsgmii) |-> port_speed_1000_only == 4'h0)
    else $error("QSGMII port limited in speed");
  bcast_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && bcast_r && waddr_r == `E3_OFS && wstrb_r == 2'h3
    |=> e3_q[0] == e3_q[1] && e3_q[2] == e3_q[3] && e3_q[0] == e3_q[3])
    else $error("broadcast write missed a port");
  read_active_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rst_r == R_ACK && raddr_r == `MMODE_OFS
    |=> rdata[15:0] == $past(mmode_q[psel_r]))
    else $error("main mode read did not return active mode");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  ams_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !mmode_q[1][`AMS_BIT] ##1 ce |=> port_media_sel[3:2] == `AMS_NONE)
    else $error("auto media choice reported while disabled");
endmodule // phy_operating_mode_config

//--- test/phy_operating_mode_config_tb.sv
// Self-checking bench for the operating-mode register bank
`timescale 1ns/1ps
`include "phy_mode_consts.svh"
module phy_operating_mode_config_tb;
  import phy_mode_pkg::*;
  logic        aclk, awready, wready, bvalid, arready, rvalid, qsg, lane0;
  logic        aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, msel, mcfg;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0]  cl = 4'hf, sl = 4'hf, fx, s1k, automatic_media_select, an, man;
  logic [1:0]  bresp, rresp, prep, rd_r;
  logic [11:0] mm;
  logic [15:0] pend[4] = '{default: 16'h0}, act[4] = '{default: 16'h0};
  int          fail_count, n_compared, sel, bc;
  // ==========================================================
  // Clock, design and watchdog
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  phy_operating_mode_config #(.SRST_CYCLES(2), .CMD_CYCLES(2)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .copper_link_in(cl),
    .serdes_link_in(sl), .mac_if_qsgmii(qsg), .mac_serdes_prep(prep),
    .qsgmii_lane0_only(lane0), .port_framing_1000x(fx),
    .port_speed_1000_only(s1k), .port_media_mode(mm), .port_ams_en(automatic_media_select),
    .port_media_sel(msel), .port_aneg_en(an), .port_mac_aneg_en(man),
    .port_media_cfg(mcfg));
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    conclude();
  end
  // ==========================================================
  // Bus tasks and model
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(a > 8'h20 ? `RESP_SLVERR : `RESP_OKAY));
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] d);
    rd(a);
    chk(rd_v, d);
    chk(32'(rd_r), 32'(a > 8'h20 ? `RESP_SLVERR : `RESP_OKAY));
  endtask
  task automatic poll(input logic [7:0] a);
    for (int k = 0; k < 40; k++) begin
      rd(a);
      if (rd_v[15] === 1'b0) break;
    end
    chk(32'(rd_v[15]), 32'h0);
  endtask
  task automatic mmw(input logic [15:0] v);
    for (int i = 0; i < 4; i++)
      if (bc != 0 || i == sel) pend[i] = v;
    wr(`MMODE_OFS, {16'h0, v});
  endtask
  task automatic srst(input logic [15:0] b);
    wr(`BCTL_OFS, {16'h0, b});
    poll(`BCTL_OFS);
    for (int i = 0; i < 4; i++)
      if (bc != 0 || i == sel) act[i] = pend[i];
    repeat (4) @(posedge aclk);
  endtask
  task automatic cmd(input logic [15:0] c);
    wr(`CMD_OFS, {16'h0, c});
    poll(`CMD_OFS);
    repeat (3) @(posedge aclk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(51519));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(`BCTL_OFS, 32'h1000);
    rdchk(8'h40, 32'h0);
    wr(8'h44, 32'h0);
    wr(`GMODE_OFS, 32'h4000);
    wr(`GMODE_OFS, 32'h8000);
    rdchk(`GMODE_OFS, 32'h4000);
    chk(32'(qsg), 32'h1);
    wr(`GMODE_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      sel = i;
      wr(`PSEL_OFS, 32'(i));
      mmw({3'h0, 1'($urandom), 1'b0, 3'($urandom_range(3, 1)), 8'h0});
      rdchk(`MMODE_OFS, {16'h0, act[i]});
      srst(pend[i][10:8] == 3'h3 ? 16'h8000 : 16'h9000);
      rdchk(`MMODE_OFS, {16'h0, act[i]});
    end
    for (int i = 0; i < 4; i++) begin
      chk(32'(mm[3*i+:3]), 32'(act[i][10:8]));
      chk(32'(fx[i]), 32'(act[i][12]));
      chk(32'(s1k[i]), 32'(act[i][12]));
      chk(32'(automatic_media_select[i]), 32'(act[i][10]));
      chk(32'(an[i]), 32'(act[i][10:8] != 3'h3));
    end
    bc = 1;
    wr(`XCTL_OFS, 32'h1);
    mmw(16'h0300);
    srst(16'h8000);
    chk(32'(mm), 32'h6db);
    chk(32'(an), 32'h0);
    bc = 0;
    wr(`XCTL_OFS, 32'h0);
    sel = 0;
    wr(`PSEL_OFS, 32'h0);
    mmw(16'h0400);
    srst(16'h9000);
    rd(`E1_OFS);
    chk(32'(rd_v[7:6]), 32'(`AMS_COPPER));
    mmw(16'h0c00);
    srst(16'h9000);
    chk(32'(msel[1:0]), 32'(`AMS_SERDES));
    chk(32'(automatic_media_select[0]), 32'h1);
    sl <= 4'h0;
    repeat (6) @(posedge aclk);
    chk(32'(msel[1:0]), 32'(`AMS_COPPER));
    wr(`E3_OFS, 32'h80);
    repeat (3) @(posedge aclk);
    chk(32'(man[0]), 32'h1);
    cmd(16'h83c1);
    cmd(16'h84d1);
    chk(32'(mcfg), 32'h25);
    cmd(16'h80f0);
    chk(32'(prep), 32'h1);
    wr(`GMODE_OFS, 32'h4000);
    cmd(16'h80e0);
    chk(32'(prep), 32'h2);
    chk(32'(lane0), 32'h1);
    rdchk(`PSTAT_OFS, 32'h6);
    conclude();
  end
endmodule // phy_operating_mode_config_tb
